// *** core/lpsw_pkg.sv ***
// package: constants, register map and types of the low-power supervisor wakeup control
package lpsw_pkg;

    // clock and timing
    localparam int CLK_MHZ            = 40;
    localparam int T_SLOW_WAKE_US     = 150;
    localparam int T_FAST_WAKE_US     = 2;
    localparam int T_OVERSHOOT_US     = 6;
    localparam int T_FULL_SETTLE_US   = 2;
    localparam int T_NORM_SETTLE_US   = 150;
    localparam int T_ENTRY_HAZARD_US  = 1;
    localparam int SLOW_WAKE_CYC      = T_SLOW_WAKE_US * CLK_MHZ;
    localparam int FAST_WAKE_CYC      = T_FAST_WAKE_US * CLK_MHZ;
    localparam int OVERSHOOT_CYC      = T_OVERSHOOT_US * CLK_MHZ;
    localparam int FULL_SETTLE_CYC    = T_FULL_SETTLE_US * CLK_MHZ;
    localparam int NORM_SETTLE_CYC    = T_NORM_SETTLE_US * CLK_MHZ;
    localparam int HAZARD_CYC         = T_ENTRY_HAZARD_US * CLK_MHZ;
    localparam int CNT_W              = 13;

    // core-level dependent oscillator limits in MHz (levels 0..3)
    localparam logic [7:0] LIM_L0_MHZ = 8'h05;
    localparam logic [7:0] LIM_L1_MHZ = 8'h08;
    localparam logic [7:0] LIM_L2_MHZ = 8'h0a;
    localparam logic [7:0] LIM_L3_MHZ = 8'h0d;

    // register offsets
    localparam logic [3:0] ADDR_CORE_CTL  = 4'h0;
    localparam logic [3:0] ADDR_HIGH_CTL  = 4'h1;
    localparam logic [3:0] ADDR_FLAGS     = 4'h2;
    localparam logic [3:0] ADDR_STATUS    = 4'h3;
    localparam logic [3:0] ADDR_MASK      = 4'h4;
    localparam logic [3:0] ADDR_CLK_CFG   = 4'h5;
    localparam logic [3:0] ADDR_STATE     = 4'h6;

    // supervisor control field positions (same for both sides)
    localparam int F_SUP_EN     = 0;
    localparam int F_SUP_KEEP   = 1;
    localparam int F_SUP_FP     = 2;
    localparam int F_MON_EN     = 3;
    localparam int F_MON_FP     = 4;
    localparam int F_AUTO       = 5;
    localparam int CTL_W        = 6;
    localparam logic [5:0] CTL_RESET = 6'h09;

    // status/event bit positions
    localparam int EV_WAKE_DONE = 0;
    localparam int EV_CORE_DLY  = 1;
    localparam int EV_HIGH_DLY  = 2;
    localparam int EV_MISSED    = 3;
    localparam int EV_LEVEL_RST = 4;
    localparam int EV_W         = 5;

    // supervisor operating state
    typedef enum logic [1:0] {
        LPSW_OFF  = 2'h0,
        LPSW_NORM = 2'h1,
        LPSW_FULL = 2'h2
    } lpsw_sup_t;

    // one supervisor/monitor pair configuration
    typedef struct packed {
        logic auto_ctl;
        logic mon_fp;
        logic mon_en;
        logic sup_fp;
        logic sup_keep;
        logic sup_en;
    } lpsw_ctl_t;

    // resolved states of one side
    typedef struct packed {
        lpsw_sup_t sup_act;
        lpsw_sup_t sup_deep;
        lpsw_sup_t mon_act;
        lpsw_sup_t mon_deep;
    } lpsw_side_t;

endpackage : lpsw_pkg

// *** core/lpsw_side_state.sv ***
// supervisor and monitor state decode for one supply side
`timescale 1ns/1ps
`default_nettype none
module lpsw_side_state
    import lpsw_pkg::*;
(
    input  wire lpsw_ctl_t  ctl,
    output var lpsw_side_t  st
);
    // active-mode and deep-sleep state of supervisor and monitor
    always_comb
    begin
        st.sup_act  = !ctl.sup_en ? LPSW_OFF : (ctl.sup_fp ? LPSW_FULL : LPSW_NORM);
        st.mon_act  = !ctl.mon_en ? LPSW_OFF : (ctl.mon_fp ? LPSW_FULL : LPSW_NORM);
        st.sup_deep = LPSW_OFF;
        if (ctl.sup_en && ctl.sup_keep)
        begin
            if (!ctl.auto_ctl)
                st.sup_deep = st.sup_act;
            else if (ctl.sup_fp)
                st.sup_deep = LPSW_NORM;
        end
        // monitor has no keep bit: manual keeps its state, auto demotes full to normal
        st.mon_deep = LPSW_OFF;
        if (ctl.mon_en)
        begin
            if (!ctl.auto_ctl)
                st.mon_deep = st.mon_act;
            else if (ctl.mon_fp)
                st.mon_deep = LPSW_NORM;
        end
    end
endmodule : lpsw_side_state
`default_nettype wire

// *** core/lpsw_timer.sv ***
// down-counting timer that holds a busy level while loaded
`timescale 1ns/1ps
`default_nettype none
module lpsw_timer
    import lpsw_pkg::*;
(
    input  wire logic               clk_sys,
    input  wire logic               rst_b,
    input  wire logic               load,
    input  wire logic [CNT_W-1:0]   count,
    output logic                    busy,
    output logic                    done
);
    logic [CNT_W-1:0] remain;

    // count down, done pulses on reaching zero
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            remain <= '0;
            done   <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (load)
                remain <= count;
            else if (remain != '0)
            begin
                remain <= remain - 1'b1;
                done   <= (remain == CNT_W'(1));
            end
        end
    end

    assign busy = (remain != '0);
endmodule : lpsw_timer
`default_nettype wire

// *** core/lpsw_ctrl.sv ***
// low-power supervisor wakeup control: supervisor states, wakeup hold-off and delay flags
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module lpsw_ctrl
    import lpsw_pkg::*;
(
    input  wire logic           clk_sys,
    input  wire logic           rst_b,
    input  wire logic [3:0]     reg_addr,
    input  wire logic [15:0]    reg_wdata,
    input  wire logic           reg_wr,
    input  wire logic           reg_rd,
    output logic [15:0]         reg_rdata,
    input  wire logic           sleep_enter,
    input  wire logic           sleep_deep,
    input  wire logic           wake_irq,
    input  wire logic           level_raise,
    output logic                cpu_hold,
    output logic                overshoot,
    output logic                subsystem_clock_fast,
    output logic                in_deep_sleep,
    output var lpsw_side_t      core_state,
    output var lpsw_side_t      high_state,
    output logic                level_reset,
    output logic                irq
);

    ////////////////////////////////////////////////////////////////////////////
    // registers and decode

    lpsw_ctl_t          core_side_control_reg;
    lpsw_ctl_t          high_side_control_reg;
    logic [EV_W-1:0]    status;
    logic [EV_W-1:0]    mask;
    logic [1:0]         core_level;
    logic               osc_main;
    logic [7:0]         osc_mhz;
    logic [EV_W-1:0]    events;
    logic               core_side_delay_flag;
    logic               high_side_delay_flag;
    logic               wr_core;
    logic               wr_high;
    logic               wr_status;

    assign wr_core   = reg_wr && (reg_addr == ADDR_CORE_CTL);
    assign wr_high   = reg_wr && (reg_addr == ADDR_HIGH_CTL);
    assign wr_status = reg_wr && (reg_addr == ADDR_STATUS);

    // supervisor control registers
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            core_side_control_reg <= lpsw_ctl_t'(CTL_RESET);
            high_side_control_reg <= lpsw_ctl_t'(CTL_RESET);
        end
        else
        begin
            if (wr_core)
                core_side_control_reg <= lpsw_ctl_t'(reg_wdata[CTL_W-1:0]);
            if (wr_high)
                high_side_control_reg <= lpsw_ctl_t'(reg_wdata[CTL_W-1:0]);
        end
    end

    // clock configuration: core level, main clock source, oscillator rate; interrupt mask
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            core_level <= 2'h0;
            osc_main   <= 1'b1;
            osc_mhz    <= 8'h01;
            mask       <= '0;
        end
        else if (reg_wr)
        begin
            if (reg_addr == ADDR_CLK_CFG)
            begin
                osc_mhz    <= reg_wdata[7:0];
                core_level <= reg_wdata[9:8];
                osc_main   <= reg_wdata[10];
            end
            if (reg_addr == ADDR_MASK)
                mask <= reg_wdata[EV_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // supervisor state decode

    lpsw_side_state u_core_side
    (
        .ctl (core_side_control_reg),
        .st  (core_state)
    );

    lpsw_side_state u_high_side
    (
        .ctl (high_side_control_reg),
        .st  (high_state)
    );

    logic       wake_fast;
    logic       osc_over_limit;
    logic [7:0] level_limit;
    logic       hazard_cfg;

    // fast when either core supervisor or monitor is off or in full performance
    assign wake_fast = (core_state.sup_act != LPSW_NORM)
                    || (core_state.mon_act != LPSW_NORM);

    // per-level oscillator limit
    always_comb
    begin
        case (core_level)
            2'h0:    level_limit = LIM_L0_MHZ;
            2'h1:    level_limit = LIM_L1_MHZ;
            2'h2:    level_limit = LIM_L2_MHZ;
            default: level_limit = LIM_L3_MHZ;
        endcase
    end

    assign osc_over_limit = osc_main && (osc_mhz > level_limit);

    // high side goes from normal to off on deep entry under fast wakeup
    assign hazard_cfg = wake_fast
        && (((high_state.sup_act == LPSW_NORM) && (high_state.sup_deep == LPSW_OFF))
         || ((high_state.mon_act == LPSW_NORM) && (high_state.mon_deep == LPSW_OFF)));

    ////////////////////////////////////////////////////////////////////////////
    // delay flags after control writes

    logic core_dly_done;
    logic high_dly_done;
    logic [CNT_W-1:0] core_settle;
    logic [CNT_W-1:0] high_settle;

    // settling time follows the newly written performance bit
    assign core_settle = reg_wdata[F_SUP_FP] ? CNT_W'(FULL_SETTLE_CYC)
                                             : CNT_W'(NORM_SETTLE_CYC);
    assign high_settle = core_settle;

    lpsw_timer u_core_dly
    (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .load    (wr_core),
        .count   (core_settle),
        .busy    (core_side_delay_flag),
        .done    (core_dly_done)
    );

    lpsw_timer u_high_dly
    (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .load    (wr_high),
        .count   (high_settle),
        .busy    (high_side_delay_flag),
        .done    (high_dly_done)
    );

    // raising the level while the core supervisor is in full performance resets
    assign level_reset = level_raise && (core_state.sup_act == LPSW_FULL);

    ////////////////////////////////////////////////////////////////////////////
    // sleep and wakeup sequencer

    typedef enum logic [3:0] {
        LPSW_S_RUN   = 4'b0001,
        LPSW_S_SLEEP = 4'b0010,
        LPSW_S_LOST  = 4'b0100,
        LPSW_S_HOLD  = 4'b1000
    } lpsw_seq_t;

    lpsw_seq_t          seq;
    lpsw_seq_t          next_seq;
    logic [CNT_W-1:0]   entry_cnt;
    logic               entry_window;
    logic               was_deep;
    logic               hold_load;
    logic [CNT_W-1:0]   hold_cnt;
    logic               hold_busy;
    logic               hold_done;
    logic               os_busy;
    logic               miss;

    assign entry_window = (entry_cnt != '0);
    // a wake inside the entry window is lost only from deep sleep with the hazard set
    assign miss = (seq == LPSW_S_SLEEP) && was_deep && wake_irq && entry_window
               && hazard_cfg;

    // next state
    always_comb
    begin
        next_seq = seq;
        case (seq)
            LPSW_S_RUN:
                if (sleep_enter)
                    next_seq = LPSW_S_SLEEP;
            LPSW_S_SLEEP:
                if (miss)
                    next_seq = LPSW_S_LOST;
                else if (wake_irq)
                    next_seq = LPSW_S_HOLD;
            LPSW_S_LOST:
                next_seq = LPSW_S_LOST; // only reset recovers
            LPSW_S_HOLD:
                if (!hold_busy && !hold_load)
                    next_seq = LPSW_S_RUN;
            default:
                next_seq = LPSW_S_RUN;
        endcase
    end

    // state register
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            seq <= LPSW_S_RUN;
        else
            seq <= next_seq;
    end

    // entry window counter and deep flag
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            entry_cnt <= '0;
            was_deep  <= 1'b0;
        end
        else if ((seq == LPSW_S_RUN) && sleep_enter)
        begin
            entry_cnt <= CNT_W'(HAZARD_CYC);
            was_deep  <= sleep_deep;
        end
        else if (entry_window)
            entry_cnt <= entry_cnt - 1'b1;
    end

    // hold-off length picked on wakeup
    assign hold_load = (seq == LPSW_S_SLEEP) && wake_irq && !miss;
    always_comb
    begin
        if (!was_deep)
            hold_cnt = CNT_W'(1);
        else if (!wake_fast)
            hold_cnt = CNT_W'(SLOW_WAKE_CYC);
        else if (osc_over_limit)
            hold_cnt = CNT_W'(FAST_WAKE_CYC);
        else
            hold_cnt = CNT_W'(SLOW_WAKE_CYC);
    end

    lpsw_timer u_hold
    (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .load    (hold_load),
        .count   (hold_cnt),
        .busy    (hold_busy),
        .done    (hold_done)
    );

    lpsw_timer u_overshoot
    (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .load    (hold_load && was_deep),
        .count   (CNT_W'(OVERSHOOT_CYC)),
        .busy    (os_busy),
        .done    ()
    );

    // cpu held while asleep, lost, or inside the hold-off
    assign cpu_hold             = (seq != LPSW_S_RUN);
    assign overshoot            = os_busy;
    assign subsystem_clock_fast = os_busy && osc_main;
    assign in_deep_sleep        = (seq == LPSW_S_SLEEP) && was_deep;

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status

    assign events = {level_reset, miss, high_dly_done, core_dly_done, hold_done};

    // sticky status, set wins over write-one-to-clear
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            status <= '0;
        else if (wr_status)
            status <= (status & ~reg_wdata[EV_W-1:0]) | events;
        else
            status <= status | events;
    end

    assign irq = |(status & mask);

    ////////////////////////////////////////////////////////////////////////////
    // read port

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            reg_rdata <= 16'h0000;
        else if (reg_rd)
        begin
            case (reg_addr)
                ADDR_CORE_CTL: reg_rdata <= 16'(core_side_control_reg);
                ADDR_HIGH_CTL: reg_rdata <= 16'(high_side_control_reg);
                ADDR_FLAGS:    reg_rdata <= {14'h0, high_side_delay_flag,
                                             core_side_delay_flag};
                ADDR_STATUS:   reg_rdata <= 16'(status);
                ADDR_MASK:     reg_rdata <= 16'(mask);
                ADDR_CLK_CFG:  reg_rdata <= {5'h00, osc_main, core_level, osc_mhz};
                ADDR_STATE:    reg_rdata <= {10'h000, hazard_cfg, wake_fast, seq};
                default:       reg_rdata <= 16'h0000;
            endcase
        end
        else
            reg_rdata <= 16'h0000;
    end

endmodule : lpsw_ctrl
`default_nettype wire

// *** test/lpsw_ctrl_sva.sv ***
// checker: port-level assertions of the supervisor wakeup control
`timescale 1ns/1ps
`default_nettype none
module lpsw_ctrl_sva
    import lpsw_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic        level_raise,
    input wire logic        cpu_hold,
    input wire logic        overshoot,
    input wire logic        subsystem_clock_fast,
    input wire logic        in_deep_sleep,
    input wire lpsw_side_t  core_state,
    input wire logic        level_reset
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    int ov_cnt;

    // length of the overshoot window since the last deep wakeup
    always_ff @(posedge clk_sys or negedge rst_b)
        if (!rst_b)
            ov_cnt <= 0;
        else
            ov_cnt <= (overshoot && !in_deep_sleep) ? ov_cnt + 1 : 0;

    ////////////////////////////////////////////////////////////////////
    property p_lvl_rst;
        level_raise && core_state.sup_act == LPSW_FULL |-> level_reset;
    endproperty
    a_lvl_rst: assert property (p_lvl_rst) else $error("no reset on raise");
    property p_lvl_norm;
        level_reset |-> level_raise && core_state.sup_act == LPSW_FULL;
    endproperty
    a_lvl_norm: assert property (p_lvl_norm) else $error("stray reset");
    property p_ov_len;
        ov_cnt <= OVERSHOOT_CYC;
    endproperty
    a_ov_len: assert property (p_ov_len) else $error("overshoot too long");
    property p_sub_fast;
        subsystem_clock_fast |-> overshoot;
    endproperty
    a_sub_fast: assert property (p_sub_fast) else $error("fast clock off window");
    property p_asleep;
        in_deep_sleep |-> cpu_hold;
    endproperty
    a_asleep: assert property (p_asleep) else $error("cpu runs asleep");
    property p_wake_hold;
        $fell(in_deep_sleep) |-> cpu_hold [*8];
    endproperty
    a_wake_hold: assert property (p_wake_hold) else $error("hold too short");
    property p_deep_off;
        core_state.sup_act == LPSW_OFF |-> core_state.sup_deep == LPSW_OFF;
    endproperty
    a_deep_off: assert property (p_deep_off) else $error("off sup on in deep");
    property p_deep_full;
        core_state.sup_deep == LPSW_FULL |-> core_state.sup_act == LPSW_FULL;
    endproperty
    a_deep_full: assert property (p_deep_full) else $error("deep full bad");
    property p_mon_deep;
        core_state.mon_deep != LPSW_OFF |-> core_state.mon_act != LPSW_OFF;
    endproperty
    a_mon_deep: assert property (p_mon_deep) else $error("off mon on in deep");
endmodule : lpsw_ctrl_sva

bind lpsw_ctrl lpsw_ctrl_sva u_sva (
    .clk_sys(clk_sys), .rst_b(rst_b), .level_raise(level_raise),
    .cpu_hold(cpu_hold), .overshoot(overshoot),
    .subsystem_clock_fast(subsystem_clock_fast), .in_deep_sleep(in_deep_sleep),
    .core_state(core_state), .level_reset(level_reset)
);
`default_nettype wire

// *** test/lpsw_testbench.sv ***
// testbench: register, sleep and wakeup scenarios of the supervisor control
`timescale 1ns/1ps
`default_nettype none
module testbench
    import lpsw_pkg::*;
;
    logic        clk_sys, rst_b, reg_wr, reg_rd, sleep_enter, sleep_deep;
    logic        wake_irq, level_raise, cpu_hold, overshoot, sub_fast;
    logic        in_deep, level_reset, irq;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    lpsw_side_t  core_state, high_state;
    logic [31:0] seed;
    logic [7:0]  lim [4];
    int          bad_count, n_tests, n, i;

    lpsw_ctrl u_dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sleep_enter(sleep_enter), .sleep_deep(sleep_deep),
        .wake_irq(wake_irq), .level_raise(level_raise), .cpu_hold(cpu_hold),
        .overshoot(overshoot), .subsystem_clock_fast(sub_fast),
        .in_deep_sleep(in_deep), .core_state(core_state),
        .high_state(high_state), .level_reset(level_reset), .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////
    // clock and watchdog
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial
    begin
        repeat (50000) @(posedge clk_sys);
        bad_count++;
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    // expected active and deep states of one side
    function automatic lpsw_side_t exp_side(input lpsw_ctl_t c);
        lpsw_side_t s;
        s.sup_act = !c.sup_en ? LPSW_OFF : (c.sup_fp ? LPSW_FULL : LPSW_NORM);
        s.mon_act = !c.mon_en ? LPSW_OFF : (c.mon_fp ? LPSW_FULL : LPSW_NORM);
        if (!c.auto_ctl)
            s.sup_deep = c.sup_keep ? s.sup_act : LPSW_OFF;
        else
            s.sup_deep = (c.sup_keep && s.sup_act == LPSW_FULL) ? LPSW_NORM : LPSW_OFF;
        s.mon_deep = !c.auto_ctl ? s.mon_act
                   : (s.mon_act == LPSW_FULL ? LPSW_NORM : LPSW_OFF);
        return s;
    endfunction : exp_side

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("Error t=%0t got %h exp %h", $time, got, exp);
            bad_count++;
        end
    endtask : chk

    task automatic chk_len(input int got, input int lo, input int hi);
        n_tests++;
        if (got < lo || got > hi)
        begin
            $display("Error t=%0t got %h exp %h", $time, got, lo);
            bad_count++;
        end
    endtask : chk_len

    // register bus cycles
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd

    // enter sleep, wake after gap cycles, count held cycles
    task automatic sleep_wake(input logic deep, input int gap, output int cnt);
        @(posedge clk_sys);
        sleep_enter <= 1'b1;
        sleep_deep <= deep;
        @(posedge clk_sys);
        sleep_enter <= 1'b0;
        repeat (gap) @(posedge clk_sys);
        chk({15'h0, in_deep}, {15'h0, deep});
        wake_irq <= 1'b1;
        @(posedge clk_sys);
        wake_irq <= 1'b0;
        cnt = 0;
        @(negedge clk_sys);
        while (cpu_hold === 1'b1 && cnt < 7000)
        begin
            @(negedge clk_sys);
            cnt++;
        end
    endtask : sleep_wake

    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        {rst_b, reg_wr, reg_rd, sleep_enter, sleep_deep, wake_irq} = 6'h00;
        level_raise = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        seed = 32'hce0a;
        lim = '{LIM_L0_MHZ, LIM_L1_MHZ, LIM_L2_MHZ, LIM_L3_MHZ};
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd(ADDR_CORE_CTL, d);
        chk(d, {10'h000, CTL_RESET});
        rd(ADDR_CLK_CFG, d);
        chk(d, 16'h0401);
        rd(4'hf, d);
        chk(d, 16'h0000);
        for (i = 0; i < 64; i++)
        begin
            seed = xs(seed);
            wr(ADDR_CORE_CTL, 16'(i));
            wr(ADDR_HIGH_CTL, {10'h000, seed[5:0]});
            @(negedge clk_sys);
            chk({8'h00, core_state}, {8'h00, exp_side(6'(i))});
            chk({8'h00, high_state}, {8'h00, exp_side(seed[5:0])});
        end
        wr(ADDR_CORE_CTL, 16'h0007);
        wr(ADDR_HIGH_CTL, 16'h0004);
        rd(ADDR_FLAGS, d);
        chk(d & 16'h0001, 16'h0001);
        @(posedge clk_sys);
        level_raise <= 1'b1;
        @(negedge clk_sys);
        chk({15'h0, level_reset}, 16'h0001);
        @(posedge clk_sys);
        level_raise <= 1'b0;
        repeat (90) @(posedge clk_sys);
        rd(ADDR_FLAGS, d);
        chk(d, 16'h0000);
        wr(ADDR_MASK, 16'h0001);
        for (i = 0; i < 4; i++)
        begin
            wr(ADDR_CLK_CFG, {5'h00, 1'b1, 2'(i), lim[i] + 8'h01});
            sleep_wake(1'b1, 60, n);
            chk_len(n, FAST_WAKE_CYC - 2, FAST_WAKE_CYC + 3);
            chk({14'h0, overshoot, sub_fast}, 16'h0003);
        end
        repeat (OVERSHOOT_CYC) @(posedge clk_sys);
        @(negedge clk_sys);
        chk({14'h0, overshoot, sub_fast}, 16'h0000);
        chk({15'h0, irq}, 16'h0001);
        wr(ADDR_MASK, 16'h0000);
        @(negedge clk_sys);
        chk({15'h0, irq}, 16'h0000);
        wr(ADDR_MASK, 16'h0001);
        wr(ADDR_STATUS, 16'h001f);
        rd(ADDR_STATUS, d);
        chk(d, 16'h0000);
        chk({15'h0, irq}, 16'h0000);
        wr(ADDR_CLK_CFG, {5'h00, 1'b1, 2'h3, (lim[3] + 8'h01) >> 1});
        sleep_wake(1'b1, 60, n);
        chk_len(n, SLOW_WAKE_CYC - 2, SLOW_WAKE_CYC + 3);
        sleep_wake(1'b0, 60, n);
        chk_len(n, 0, 4);
        wr(ADDR_CORE_CTL, 16'h0009);
        repeat (5900) @(posedge clk_sys);
        rd(ADDR_FLAGS, d);
        chk(d & 16'h0001, 16'h0001);
        repeat (150) @(posedge clk_sys);
        rd(ADDR_FLAGS, d);
        chk(d, 16'h0000);
        sleep_wake(1'b1, 60, n);
        chk_len(n, SLOW_WAKE_CYC - 2, SLOW_WAKE_CYC + 3);
        chk({15'h0, overshoot}, 16'h0000);
        wr(ADDR_CORE_CTL, 16'h0007);
        wr(ADDR_HIGH_CTL, 16'h0028);
        repeat (6010) @(posedge clk_sys);
        sleep_wake(1'b1, 5, n);
        chk_len(n, 7000, 7000);
        rd(ADDR_STATUS, d);
        chk(d & 16'h0008, 16'h0008);
        @(posedge clk_sys);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(negedge clk_sys);
        chk({15'h0, cpu_hold}, 16'h0000);
        finish_test();
    end
endmodule : testbench
`default_nettype wire
